//--- logic/drive_digital_io_routing.sv
// Overview of operation
// [RQ1] Input status word mirrors inputs 0 to 9
// [RQ2] Full variant fixed input defaults all modes
// [RQ3] Inputs 4,5,7,8 defaults in pulse/speed mode
// [RQ4] Torque mode: input 5 torque source, 7/8 enables
// [RQ5] Basic variant: only inputs 2 to 7
// [RQ6] Full variant has outputs 0 to 5
// [RQ7] Basic variant has outputs 2 to 5
// [RQ8] Each output has its own source selector
// [RQ9] Ready flag low on fault or missing enable
// [RQ10] Ready-for-servo-on flag
// [RQ11] Fault flag while in fault state
// [RQ12] In-position when droop within range
// [RQ13] In-position only in pulse mode
// [RQ14] Zero speed flag with hysteresis
// [RQ15] Torque limit flag near either limit
// [RQ16] Torque limit flag low otherwise
// [RQ17] Unselected output low; inputs resampled
`timescale 1ns/1ns
`default_nettype none
module drive_digital_io_routing (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Variant strap, high for the full variant
  input wire logic full_variant_strap,
  // Terminals
  input wire logic [io_route_pkg::NUM_DI-1:0] digital_input_pin,
  output logic [io_route_pkg::NUM_DO-1:0] digital_output_pin,
  // Converter state
  input wire logic converter_ready,
  input wire logic enable_missing,
  input wire logic fault_state,
  input wire logic servo_on_ready,
  input wire logic [15:0] droop_count,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] torque_act,
  input wire logic [15:0] torque_pos_limit,
  input wire logic [15:0] torque_neg_limit,
  // Input functions
  output logic cw_travel_limit,
  output logic ccw_travel_limit,
  output logic servo_on_cmd,
  output logic fault_ack_cmd,
  output logic fixed_speed_bit0,
  output logic pulse_setpoint_inhibit,
  output logic zero_clamp_enable,
  output logic torque_source_select,
  output logic quick_stop_release,
  output logic gear_select_bit0,
  output logic ccw_rotation_enable,
  output logic cw_rotation_enable,
  output logic droop_clear,
  output logic mode_switch_cmd,
  // Interrupt
  output logic irq
);
  import io_route_pkg::*;

  logic [NUM_DI-1:0] din_lvl;
  logic [NUM_DI-1:0] din_state;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] flags_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Variant strap, caught on the first edge after reset release

  logic full_r, full_nxt, strap_done_r, strap_done_nxt;

  always_comb begin
    full_nxt = strap_done_r ? full_r : full_variant_strap;
    strap_done_nxt = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_r <= 1'b0;
      strap_done_r <= 1'b0;
    end else begin
      full_r <= full_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling

  // [RQ17] Inputs resampled on pclk
  input_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(digital_input_pin),
    .level_out(din_lvl)
  );

  // [RQ1] [RQ5] Status word, absent inputs read zero on basic variant
  always_comb begin
    din_state = din_lvl;
    if (!full_r) begin
      din_state[0] = 1'b0;
      din_state[1] = 1'b0;
      din_state[8] = 1'b0;
      din_state[9] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers written by software

  mode_t mode_r, mode_nxt;
  logic [NUM_DO*SEL_W-1:0] sel_r, sel_nxt;
  logic [15:0] inp_range_r, inp_range_nxt;
  logic [15:0] zsp_thresh_r, zsp_thresh_nxt;
  logic [15:0] tlr_hyst_r, tlr_hyst_nxt;
  logic [NUM_FLAGS-1:0] mask_r, mask_nxt;
  logic [NUM_FLAGS-1:0] ists_r, ists_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic wr_acc, rd_acc, mapped;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;

  // Address decode
  always_comb begin
    case (paddr)
      OFS_DIN_STATE, OFS_CTRL, OFS_DOUT_SEL, OFS_INP_RANGE, OFS_ZSP_THRESH,
      OFS_TLR_HYST, OFS_FLAGS, OFS_IRQ_STATUS, OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Register writes in the access cycle, read data capture in the setup cycle
  always_comb begin
    mode_nxt = mode_r;
    sel_nxt = sel_r;
    inp_range_nxt = inp_range_r;
    zsp_thresh_nxt = zsp_thresh_r;
    tlr_hyst_nxt = tlr_hyst_r;
    mask_nxt = mask_r;
    prdata_nxt = prdata_r;
    if (wr_acc) begin
      case (paddr)
        OFS_CTRL: begin
          case (pwdata[CTRL_MODE_LSB +: 2])
            2'h1: mode_nxt = MODE_SPEED;
            2'h2: mode_nxt = MODE_TORQUE;
            default: mode_nxt = MODE_PULSE;
          endcase
        end
        // [RQ8] Per-output selectors
        OFS_DOUT_SEL: sel_nxt = pwdata[NUM_DO*SEL_W-1:0];
        OFS_INP_RANGE: inp_range_nxt = pwdata[15:0];
        OFS_ZSP_THRESH: zsp_thresh_nxt = pwdata[15:0];
        OFS_TLR_HYST: tlr_hyst_nxt = pwdata[15:0];
        OFS_IRQ_MASK: mask_nxt = pwdata[NUM_FLAGS-1:0];
        default: ;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_DIN_STATE: prdata_nxt = {22'h000000, din_state};
        OFS_CTRL: prdata_nxt = {27'h0000000, full_r, 2'h0, mode_r};
        OFS_DOUT_SEL: prdata_nxt = {14'h0000, sel_r};
        OFS_INP_RANGE: prdata_nxt = {16'h0000, inp_range_r};
        OFS_ZSP_THRESH: prdata_nxt = {16'h0000, zsp_thresh_r};
        OFS_TLR_HYST: prdata_nxt = {16'h0000, tlr_hyst_r};
        OFS_FLAGS: prdata_nxt = {18'h00000, 2'h0, digital_output_pin, flags};
        OFS_IRQ_STATUS: prdata_nxt = {26'h0000000, ists_r};
        OFS_IRQ_MASK: prdata_nxt = {26'h0000000, mask_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= mode_t'(CTRL_MODE_RST);
      sel_r <= DOUT_SEL_RST;
      inp_range_r <= INP_RANGE_RST;
      zsp_thresh_r <= ZSP_THRESH_RST;
      tlr_hyst_r <= TLR_HYST_RST;
      mask_r <= IRQ_MASK_RST;
      prdata_r <= 32'h00000000;
    end else begin
      mode_r <= mode_nxt;
      sel_r <= sel_nxt;
      inp_range_r <= inp_range_nxt;
      zsp_thresh_r <= zsp_thresh_nxt;
      tlr_hyst_r <= tlr_hyst_nxt;
      mask_r <= mask_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  status_flags u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .converter_ready(converter_ready),
    .enable_missing(enable_missing),
    .fault_state(fault_state),
    .servo_on_ready(servo_on_ready),
    .mode(mode_r),
    .droop_count(droop_count),
    .motor_speed(motor_speed),
    .torque_act(torque_act),
    .torque_pos_limit(torque_pos_limit),
    .torque_neg_limit(torque_neg_limit),
    .inp_range(inp_range_r),
    .zsp_thresh(zsp_thresh_r),
    .tlr_hyst(tlr_hyst_r),
    .flags(flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: rising flag edges are sticky, read of status clears

  always_comb begin
    ists_nxt = ists_r;
    if (rd_acc && paddr == OFS_IRQ_STATUS) begin
      // Clear only bits reported, so an event in the setup cycle survives
      ists_nxt = ists_r & ~prdata_r[NUM_FLAGS-1:0];
    end
    ists_nxt = ists_nxt | (flags & ~flags_d_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_r <= '0;
      flags_d_r <= '0;
    end else begin
      ists_r <= ists_nxt;
      flags_d_r <= flags;
    end
  end

  assign irq = |(ists_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Output routing

  logic [NUM_DO-1:0] dout_r, dout_nxt;

  genvar g;
  generate
    for (g = 0; g < NUM_DO; g++) begin : g_dout
      logic [SEL_W-1:0] code;
      logic src;
      assign code = sel_r[g*SEL_W +: SEL_W];
      // [RQ8] [RQ17] Selector picks flag, no source drives low
      always_comb begin
        case (src_t'(code))
          SRC_READY: src = flags[0];
          SRC_READY_ON: src = flags[1];
          SRC_FAULT: src = flags[2];
          SRC_INPOS: src = flags[3];
          SRC_ZERO_SPEED: src = flags[4];
          SRC_TORQUE_LIM: src = flags[5];
          default: src = 1'b0;
        endcase
      end
      // [RQ6] [RQ7] Outputs 0 and 1 exist on full variant only
      assign dout_nxt[g] = (g < 2) ? (src & full_r) : src;
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_r <= '0;
    end else begin
      dout_r <= dout_nxt;
    end
  end

  assign digital_output_pin = dout_r;

  ////////////////////////////////////////////////////////////////////////////
  // Default input functions

  logic [13:0] fn_r, fn_nxt;

  always_comb begin
    fn_nxt = '0;
    // [RQ2] Fixed defaults, full variant
    fn_nxt[0] = full_r & din_lvl[0];
    fn_nxt[1] = full_r & din_lvl[1];
    fn_nxt[13] = full_r & din_lvl[9];
    // [RQ2] [RQ5] Both variants
    fn_nxt[2] = din_lvl[2];
    fn_nxt[3] = din_lvl[3];
    fn_nxt[8] = din_lvl[6];
    if (!full_r) begin
      // [RQ5] Basic variant, input 4 unassigned
      fn_nxt[5] = din_lvl[5];
      fn_nxt[9] = din_lvl[7];
    end else begin
      case (mode_r)
        // [RQ3] Pulse mode defaults
        MODE_PULSE: begin
          fn_nxt[5] = din_lvl[5];
          fn_nxt[9] = din_lvl[7];
          fn_nxt[12] = din_lvl[8];
        end
        // [RQ3] Speed mode defaults
        MODE_SPEED: begin
          fn_nxt[4] = din_lvl[4];
          fn_nxt[6] = din_lvl[5];
          fn_nxt[10] = din_lvl[7];
          fn_nxt[11] = din_lvl[8];
        end
        // [RQ4] Torque mode defaults
        MODE_TORQUE: begin
          fn_nxt[7] = din_lvl[5];
          fn_nxt[10] = din_lvl[7];
          fn_nxt[11] = din_lvl[8];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fn_r <= '0;
    end else begin
      fn_r <= fn_nxt;
    end
  end

  assign cw_travel_limit = fn_r[0];
  assign ccw_travel_limit = fn_r[1];
  assign servo_on_cmd = fn_r[2];
  assign fault_ack_cmd = fn_r[3];
  assign fixed_speed_bit0 = fn_r[4];
  assign pulse_setpoint_inhibit = fn_r[5];
  assign zero_clamp_enable = fn_r[6];
  assign torque_source_select = fn_r[7];
  assign quick_stop_release = fn_r[8];
  assign gear_select_bit0 = fn_r[9];
  assign ccw_rotation_enable = fn_r[10];
  assign cw_rotation_enable = fn_r[11];
  assign droop_clear = fn_r[12];
  assign mode_switch_cmd = fn_r[13];

endmodule // drive_digital_io_routing
`default_nettype wire

//--- logic/input_sync.sv
`timescale 1ns/1ns
`default_nettype none
module input_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw pins and filtered levels
  input wire logic [io_route_pkg::NUM_DI-1:0] pin_in,
  output logic [io_route_pkg::NUM_DI-1:0] level_out
);
  import io_route_pkg::*;

  genvar i;
  generate
    for (i = 0; i < NUM_DI; i++) begin : g_bit
      logic s1_r, s2_r, s3_r, lvl_r;
      logic lvl_nxt;
      // Level follows once second and third stage agree
      always_comb begin
        lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
      end
      // Three stage synchroniser plus held level
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          lvl_r <= 1'b0;
        end else begin
          s1_r <= pin_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          lvl_r <= lvl_nxt;
        end
      end
      assign level_out[i] = lvl_r;
    end
  endgenerate

endmodule // input_sync
`default_nettype wire

//--- logic/io_route_pkg.sv
package io_route_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_DIN_STATE = 12'h000;
  localparam logic [11:0] OFS_CTRL = 12'h004;
  localparam logic [11:0] OFS_DOUT_SEL = 12'h008;
  localparam logic [11:0] OFS_INP_RANGE = 12'h00C;
  localparam logic [11:0] OFS_ZSP_THRESH = 12'h010;
  localparam logic [11:0] OFS_TLR_HYST = 12'h014;
  localparam logic [11:0] OFS_FLAGS = 12'h018;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h01C;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h020;

  // Sizes
  localparam int NUM_DI = 10;
  localparam int NUM_DO = 6;
  localparam int NUM_FLAGS = 6;
  localparam int SEL_W = 3;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FULL_POS = 4;

  // Reset values
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;
  localparam logic [17:0] DOUT_SEL_RST = 18'h00000;
  localparam logic [15:0] INP_RANGE_RST = 16'h000A;
  localparam logic [15:0] ZSP_THRESH_RST = 16'h000A;
  localparam logic [15:0] TLR_HYST_RST = 16'h0010;
  localparam logic [5:0] IRQ_MASK_RST = 6'h00;

  // Zero speed hysteresis in r/min, speed word is 1 r/min per LSB
  localparam logic [16:0] ZSP_HYST_RPM = 17'h0000A;

  // Control modes
  typedef enum logic [1:0] {
    MODE_PULSE = 2'b00,
    MODE_SPEED = 2'b01,
    MODE_TORQUE = 2'b10
  } mode_t;

  // Output source selector codes; also bit index + 1 in the flag word
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_READY = 3'b001,
    SRC_READY_ON = 3'b010,
    SRC_FAULT = 3'b011,
    SRC_INPOS = 3'b100,
    SRC_ZERO_SPEED = 3'b101,
    SRC_TORQUE_LIM = 3'b110
  } src_t;

endpackage

//--- logic/status_flags.sv
`timescale 1ns/1ns
`default_nettype none
module status_flags (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Converter state
  input wire logic converter_ready,
  input wire logic enable_missing,
  input wire logic fault_state,
  input wire logic servo_on_ready,
  input wire io_route_pkg::mode_t mode,
  // Measured values
  input wire logic [15:0] droop_count,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] torque_act,
  input wire logic [15:0] torque_pos_limit,
  input wire logic [15:0] torque_neg_limit,
  // Settings
  input wire logic [15:0] inp_range,
  input wire logic [15:0] zsp_thresh,
  input wire logic [15:0] tlr_hyst,
  // Flags, bit order as src_t minus one
  output logic [io_route_pkg::NUM_FLAGS-1:0] flags
);
  import io_route_pkg::*;

  logic [NUM_FLAGS-1:0] flags_r, flags_nxt;
  logic zsp_nxt;
  logic [15:0] droop_mag;
  logic signed [17:0] t_act, t_pos, t_neg;

  // Next flag values
  always_comb begin
    droop_mag = droop_count[15] ? 16'(-droop_count) : droop_count;
    t_act = 18'(signed'(torque_act));
    t_pos = $signed({2'b00, torque_pos_limit}) - $signed({2'b00, tlr_hyst});
    t_neg = $signed({2'b00, tlr_hyst}) - $signed({2'b00, torque_neg_limit});
    // [RQ14] Zero speed hysteresis
    zsp_nxt = flags_r[4];
    if (motor_speed <= zsp_thresh) begin
      zsp_nxt = 1'b1;
    end else if ({1'b0, motor_speed} > ({1'b0, zsp_thresh} + ZSP_HYST_RPM)) begin
      zsp_nxt = 1'b0;
    end
    // [RQ9] Ready needs no fault
    flags_nxt[0] = converter_ready & ~fault_state & ~enable_missing;
    // [RQ10] Ready for servo-on
    flags_nxt[1] = servo_on_ready;
    // [RQ11] Fault present
    flags_nxt[2] = fault_state;
    // [RQ12] [RQ13] In-position, pulse mode only
    flags_nxt[3] = (mode == MODE_PULSE) && (droop_mag <= inp_range);
    flags_nxt[4] = zsp_nxt;
    // [RQ15] [RQ16] Torque limit reached
    flags_nxt[5] = (t_act >= t_pos) || (t_act <= t_neg);
  end

  // Flag registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

endmodule // status_flags
`default_nettype wire

//--- sim/drive_digital_io_routing_test.sv
`timescale 1ns/1ns
`default_nettype none
module drive_digital_io_routing_test;
  import io_route_pkg::*;
  typedef struct packed {logic [1:0] mode; logic [9:0] pins; logic [13:0] fn;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq, strap, slow;
  logic conv_rdy, en_miss, fault, son_rdy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] pins, levels;
  logic [5:0] dout;
  logic [13:0] fn;
  logic [15:0] droop, speed, torque;
  int mismatches, checks_done;
  row_t rows [8] = '{'{2'h0, 10'h3FF, 14'h3D33}, '{2'h1, 10'h3FF, 14'h3EAD},
    '{2'h2, 10'h3FF, 14'h3C6D}, '{2'h0, 10'h155, 14'h2822}, '{2'h1, 10'h2AA, 14'h1489},
    '{2'h2, 10'h155, 14'h2824}, '{2'h1, 10'h010, 14'h0200}, '{2'h3, 10'h3FF, 14'h3D33}};
  logic [15:0] sp [8] = '{16'h14, 16'h15, 16'h0B, 16'h0A, 16'h0A, 16'h0A, 16'h0A, 16'h0A};
  logic [15:0] tq [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h54, 16'h53, 16'hFFAC, 16'hFFAD};
  logic [5:0] ex [8] = '{6'h11, 6'h01, 6'h01, 6'h11, 6'h31, 6'h11, 6'h31, 6'h11};
  ////////////////////////////////////////
  // Far side and block under test
  plc_terminal_model plc_terminal_model_inst (.pclk(pclk), .level_cmd(levels), .slow(slow),
    .pin_drive(pins));
  drive_digital_io_routing drive_digital_io_routing_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .full_variant_strap(strap),
    .digital_input_pin(pins), .digital_output_pin(dout), .converter_ready(conv_rdy),
    .enable_missing(en_miss), .fault_state(fault), .servo_on_ready(son_rdy),
    .droop_count(droop), .motor_speed(speed), .torque_act(torque),
    .torque_pos_limit(16'h0064), .torque_neg_limit(16'h0064), .cw_travel_limit(fn[13]),
    .ccw_travel_limit(fn[12]), .servo_on_cmd(fn[11]), .fault_ack_cmd(fn[10]),
    .fixed_speed_bit0(fn[9]), .pulse_setpoint_inhibit(fn[8]), .zero_clamp_enable(fn[7]),
    .torque_source_select(fn[6]), .quick_stop_release(fn[5]), .gear_select_bit0(fn[4]),
    .ccw_rotation_enable(fn[3]), .cw_rotation_enable(fn[2]), .droop_clear(fn[1]),
    .mode_switch_cmd(fn[0]), .irq(irq));
  ////////////////////////////////////////
  // One bus transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // The wait ends when pready is high; only the watchdog ends one where pready never rises
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Compare and count
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask
  // Flags and selected outputs side by side
  task automatic flg_chk(input logic [5:0] e);
    repeat (4) @(posedge pclk);
    rdchk(OFS_FLAGS, {20'h0, e, e});
    cmp({26'h0, dout}, {26'h0, e});
  endtask
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Watchdog
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  // Main sequence
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; strap = 1;
    levels = 0; slow = 0; conv_rdy = 0; en_miss = 0; fault = 0; son_rdy = 0;
    droop = 0; speed = 0; torque = 0; mismatches = 0; checks_done = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdchk(OFS_CTRL, 32'h10);
    rdchk(OFS_DOUT_SEL, 32'h0);
    rdchk(OFS_INP_RANGE, 32'hA);
    rdchk(OFS_ZSP_THRESH, 32'hA);
    rdchk(OFS_TLR_HYST, 32'h10);
    rdchk(OFS_IRQ_MASK, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, OFS_CTRL, {30'h0, rows[i].mode});
      @(posedge pclk);
      levels <= rows[i].pins;
      slow <= i[0];
      repeat (12) @(posedge pclk);
      cmp({18'h0, fn}, {18'h0, rows[i].fn});
      rdchk(OFS_DIN_STATE, {22'h0, rows[i].pins});
    end
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_DOUT_SEL, 32'h358D1);
    flg_chk(6'h18);
    conv_rdy <= 1; son_rdy <= 1;
    flg_chk(6'h1B);
    fault <= 1;
    flg_chk(6'h1E);
    fault <= 0; en_miss <= 1;
    flg_chk(6'h1A);
    en_miss <= 0; son_rdy <= 0; droop <= 16'hFFF5;
    flg_chk(6'h11);
    droop <= 16'hFFF6;
    flg_chk(6'h19);
    apb(1'b1, OFS_CTRL, 32'h1);
    flg_chk(6'h11);
    for (int k = 0; k < 8; k++) begin
      speed <= sp[k];
      torque <= tq[k];
      flg_chk(ex[k]);
    end
    apb(1'b1, OFS_DOUT_SEL, 32'h3F000);
    rdchk(OFS_FLAGS, 32'h11);
    cmp({26'h0, dout}, 32'h0);
    // Interrupt raise, clear and mask
    apb(1'b1, OFS_IRQ_MASK, 32'h4);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    fault <= 1;
    repeat (4) @(posedge pclk);
    cmp(irq, 1);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    cmp(rd & 32'h4, 32'h4);
    @(posedge pclk);
    cmp(irq, 0);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    fault <= 0;
    repeat (3) @(posedge pclk);
    fault <= 1;
    repeat (4) @(posedge pclk);
    cmp(irq, 0);
    // Status word is read-only; pins still all high from the last row
    apb(1'b1, OFS_DIN_STATE, 32'hFFFFFFFF);
    rdchk(OFS_DIN_STATE, 32'h3FF);
    apb(1'b0, 12'h040, 32'h0);
    cmp(err, 1);
    cmp(rd, 0);
    // Basic variant after a second reset
    presetn <= 0; strap <= 0; levels <= 10'h3FF; slow <= 0; fault <= 0; son_rdy <= 1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdchk(OFS_CTRL, 32'h0);
    repeat (12) @(posedge pclk);
    cmp({18'h0, fn}, {18'h0, 14'h0D30});
    rdchk(OFS_DIN_STATE, 32'h0FC);
    apb(1'b1, OFS_DOUT_SEL, 32'h358D1);
    repeat (4) @(posedge pclk);
    rdchk(OFS_FLAGS, 32'h61B);
    cmp({26'h0, dout}, 32'h18);
    conclude();
  end
endmodule // drive_digital_io_routing_test
`default_nettype wire

//--- sim/io_route_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module io_route_monitor (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Terminals and functions
  input wire logic full_variant_strap,
  input wire logic [io_route_pkg::NUM_DI-1:0] digital_input_pin,
  input wire logic [io_route_pkg::NUM_DO-1:0] digital_output_pin,
  input wire logic cw_travel_limit,
  input wire logic ccw_travel_limit,
  input wire logic servo_on_cmd,
  input wire logic droop_clear,
  input wire logic cw_rotation_enable,
  input wire logic mode_switch_cmd,
  input wire logic irq
);
  import io_route_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of a transfer
  wire acc = psel && penable;
  ////////////////////////////////////////
  a_ready_tied: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && paddr > OFS_IRQ_MASK |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access accepted");
  a_err_mapped: assert property (acc && paddr <= OFS_IRQ_MASK && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access refused");
  a_basic_outputs: assert property (!full_variant_strap
    |-> digital_output_pin[1:0] == 2'h0) else $error("basic output 0 or 1 driven");
  a_basic_inputs: assert property (!full_variant_strap |-> !(cw_travel_limit ||
    ccw_travel_limit || droop_clear || cw_rotation_enable || mode_switch_cmd))
    else $error("basic missing input routed");
  a_cw_follow: assert property ((full_variant_strap && digital_input_pin[0]) [*8]
    |-> cw_travel_limit) else $error("travel limit not routed");
  a_servo_follow: assert property ($stable(digital_input_pin[2]) [*8]
    |-> servo_on_cmd == digital_input_pin[2]) else $error("servo on not routed");
  a_irq_drop_cause: assert property ($fell(irq) |-> $past(acc &&
    (paddr == OFS_IRQ_STATUS || pwrite && paddr == OFS_IRQ_MASK)))
    else $error("irq fell without clear");
endmodule // io_route_monitor
bind drive_digital_io_routing io_route_monitor io_route_monitor_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .full_variant_strap,
  .digital_input_pin, .digital_output_pin, .cw_travel_limit, .ccw_travel_limit,
  .servo_on_cmd, .droop_clear, .cw_rotation_enable, .mode_switch_cmd, .irq);
`default_nettype wire

//--- sim/plc_terminal_model.sv
`timescale 1ns/1ns
`default_nettype none
module plc_terminal_model (
  // Clock
  input wire logic pclk,
  // Commanded contact levels and pacing
  input wire logic [9:0] level_cmd,
  input wire logic slow,
  // Wiring toward the converter
  output logic [9:0] pin_drive
);
  logic [9:0] lag1_r, lag2_r, lag1_nxt, lag2_nxt;
  // Contact delay line
  always_comb begin
    lag1_nxt = level_cmd;
    lag2_nxt = lag1_r;
  end
  always_ff @(posedge pclk) begin
    lag1_r <= lag1_nxt;
    lag2_r <= lag2_nxt;
  end
  // Slow relays settle two cycles late
  assign pin_drive = slow ? lag2_r : level_cmd;
endmodule // plc_terminal_model
`default_nettype wire
